// ---- tpc_timer_pair.sv ----
// module: match, toggle and control logic of one 8-bit timer pair with APB registers
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/100ps
module tpc_timer_pair
    import tpc_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        external_count_pin,
    input  wire logic        idle_standby_state,
    output logic             low_match_irq,
    output logic             high_match_irq,
    output logic             timer_output_pin
);

    ////////////////////////////////////////////////////////////////////////////
    // true when the low k prescaler bits are all ones: one tick per 2^k clocks
    function automatic logic tap_tick(input logic [8:0] p, input logic [3:0] k);
        logic [8:0] m;
        m = 9'((10'h001 << k) - 10'h001);
        return (p & m) == m;
    endfunction

    tpc_run_s    run_r,     run_nxt;
    tpc_mode_s   mode_r,    mode_nxt;
    logic [7:0]  cmp_lo_r,  cmp_lo_nxt;
    logic [7:0]  buf_lo_r,  buf_lo_nxt;
    logic [7:0]  cmp_hi_r,  cmp_hi_nxt;
    logic        armed_r,   armed_nxt;
    logic        tgl_en_r,  tgl_en_nxt;
    logic        tgl_sel_r, tgl_sel_nxt;
    logic [8:0]  presc_r,   presc_nxt;
    logic [7:0]  cnt_lo_r,  cnt_lo_nxt;
    logic [7:0]  cnt_hi_r,  cnt_hi_nxt;
    logic        ff_r,      ff_nxt;
    logic        irq_lo_r,  irq_lo_nxt;
    logic        irq_hi_r,  irq_hi_nxt;
    logic [31:0] prdata_r,  prdata_nxt;
    logic        pready_r,  pready_nxt;
    logic        pslverr_r, pslverr_nxt;
    logic        ext_s1_r,  ext_s2_r, ext_s3_r;
    logic        ext_lvl_r, ext_lvl_nxt;

    // combinational helpers
    logic        wr_acc;
    logic        rd_setup;
    logic        halt;
    logic        presc_go;
    logic        t2;
    logic        t8;
    logic        t32;
    logic        t512;
    logic        ext_rise;
    logic        lo_tick;
    logic        hi_tick;
    logic [7:0]  lo_inc;
    logic [7:0]  hi_inc;
    logic [15:0] inc16;
    logic [7:0]  pwm_top;
    logic        lo_match;
    logic        lo_cmp_hit;
    logic        ppg_end;
    logic        pwm_ovf;
    logic        match16;
    logic        hi_match;
    logic        lo_trig;
    logic        hw_tgl;
    logic        sw_wr;
    logic [1:0]  sw_cmd;
    tpc_mode_e   mode;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchroniser: the first stage feeds only the second
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ext_s1_r <= 1'b0;
            ext_s2_r <= 1'b0;
            ext_s3_r <= 1'b0;
        end else begin
            ext_s1_r <= external_count_pin;
            ext_s2_r <= ext_s1_r;
            ext_s3_r <= ext_s2_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        mode       = mode_r.operating_mode_field;
        wr_acc     = psel && penable && pready_r && pwrite;
        rd_setup   = psel && penable && !pready_r;
        // idle standby freezes the pair unless told to keep going
        halt       = idle_standby_state && !run_r.idle_keep_running;
        presc_go   = run_r.prescaler_run && !halt;
        t2         = presc_go && tap_tick(presc_r, TPC_TAP_DIV2);
        t8         = presc_go && tap_tick(presc_r, TPC_TAP_DIV8);
        t32        = presc_go && tap_tick(presc_r, TPC_TAP_DIV32);
        t512       = presc_go && tap_tick(presc_r, TPC_TAP_DIV512);

        // a rising pin change counts once stages two and three agree
        ext_lvl_nxt = (ext_s2_r == ext_s3_r) ? ext_s3_r : ext_lvl_r;
        ext_rise    = (ext_s2_r == ext_s3_r) && ext_s3_r && !ext_lvl_r;

        case (mode_r.low_clock_select)
            2'b00:   lo_tick = ext_rise && !halt;
            2'b01:   lo_tick = t2;
            2'b10:   lo_tick = t8;
            default: lo_tick = t32;
        endcase
        lo_tick = lo_tick && run_r.low_counter_run;

        case (mode_r.pwm_cycle_field)
            2'b01:   pwm_top = TPC_PWM_TOP_64;
            2'b10:   pwm_top = TPC_PWM_TOP_128;
            default: pwm_top = TPC_PWM_TOP_256;
        endcase

        // matching on the incremented value makes compare zero hit at wrap
        lo_inc     = cnt_lo_r + 8'h01;
        hi_inc     = cnt_hi_r + 8'h01;
        inc16      = {cnt_hi_r, cnt_lo_r} + 16'h0001;
        lo_cmp_hit = lo_tick && (lo_inc == cmp_lo_r);
        lo_match   = lo_cmp_hit && (mode == TPC_TIMER8);
        ppg_end    = lo_tick && (mode == TPC_PPG) && (lo_inc == cmp_hi_r);
        pwm_ovf    = lo_tick && (mode == TPC_PWM) && (cnt_lo_r == pwm_top);
        match16    = lo_tick && (mode == TPC_TIMER16) && run_r.high_counter_run
                     && armed_r && (inc16 == {cmp_hi_r, cmp_lo_r});
        lo_trig    = lo_match || pwm_ovf || ppg_end;

        if (mode == TPC_TIMER16) begin
            hi_tick = lo_tick && (cnt_lo_r == 8'hff);
        end else begin
            case (mode_r.high_clock_select)
                2'b00:   hi_tick = lo_trig;
                2'b01:   hi_tick = t2;
                2'b10:   hi_tick = t32;
                default: hi_tick = t512;
            endcase
        end
        hi_tick  = hi_tick && run_r.high_counter_run;
        hi_match = hi_tick && (mode != TPC_TIMER16) && (hi_inc == cmp_hi_r);

        case (mode)
            TPC_TIMER8:  hw_tgl = tgl_sel_r ? hi_match : lo_match;
            TPC_TIMER16: hw_tgl = match16;
            TPC_PWM:     hw_tgl = lo_cmp_hit || pwm_ovf;
            TPC_PPG:     hw_tgl = lo_cmp_hit || ppg_end;
            default:     hw_tgl = 1'b0;
        endcase
        hw_tgl = hw_tgl && tgl_en_r;

        // prescaler
        if (!run_r.prescaler_run) begin
            presc_nxt = 9'h000;
        end else if (halt) begin
            presc_nxt = presc_r;
        end else begin
            presc_nxt = presc_r + 9'h001;
        end

        // low counter
        cnt_lo_nxt = cnt_lo_r;
        buf_lo_nxt = buf_lo_r;
        cmp_lo_nxt = cmp_lo_r;
        if (lo_tick) begin
            cnt_lo_nxt = lo_inc;
        end
        if (lo_match || pwm_ovf || ppg_end || match16) begin
            cnt_lo_nxt = 8'h00;
        end
        if ((pwm_ovf || ppg_end) && run_r.double_buffer_enable) begin
            cmp_lo_nxt = buf_lo_r;
        end
        if (!run_r.low_counter_run) begin
            cnt_lo_nxt = 8'h00;
        end

        // high counter
        cnt_hi_nxt = cnt_hi_r;
        if (hi_tick) begin
            cnt_hi_nxt = hi_inc;
        end
        if (hi_match || match16) begin
            cnt_hi_nxt = 8'h00;
        end
        if (!run_r.high_counter_run) begin
            cnt_hi_nxt = 8'h00;
        end

        irq_lo_nxt = lo_match || lo_cmp_hit && (mode == TPC_PPG) || pwm_ovf;
        irq_hi_nxt = hi_match || match16;

        // register writes
        run_nxt     = run_r;
        mode_nxt    = mode_r;
        cmp_hi_nxt  = cmp_hi_r;
        armed_nxt   = armed_r;
        tgl_en_nxt  = tgl_en_r;
        tgl_sel_nxt = tgl_sel_r;
        sw_wr       = 1'b0;
        sw_cmd      = pwdata[1:0];
        if (wr_acc) begin
            case (paddr)
                TPC_ADDR_RUN: begin
                    run_nxt      = tpc_run_s'(pwdata[7:0]);
                    run_nxt.ones = TPC_RUN_ONES;
                end
                TPC_ADDR_MODE: begin
                    mode_nxt = tpc_mode_s'(pwdata[7:0]);
                end
                TPC_ADDR_CMP_LO: begin
                    buf_lo_nxt = pwdata[7:0];
                    if (!run_r.double_buffer_enable) begin
                        cmp_lo_nxt = pwdata[7:0];
                    end
                    // a low write alone leaves the 16-bit compare disarmed
                    armed_nxt = 1'b0;
                end
                TPC_ADDR_CMP_HI: begin
                    cmp_hi_nxt = pwdata[7:0];
                    armed_nxt  = 1'b1;
                end
                TPC_ADDR_TGL: begin
                    // toggle setup should only change while stopped
                    tgl_en_nxt  = pwdata[TPC_TGL_EN_BIT];
                    tgl_sel_nxt = pwdata[TPC_TGL_SEL_BIT];
                    sw_wr       = 1'b1;
                end
                default: begin
                end
            endcase
        end

        // output flip-flop; software set or clear overrides a hardware toggle
        ff_nxt = ff_r;
        if (sw_wr && sw_cmd == TPC_CMD_SET) begin
            ff_nxt = 1'b1;
        end else if (sw_wr && sw_cmd == TPC_CMD_CLEAR) begin
            ff_nxt = 1'b0;
        end else if (hw_tgl || (sw_wr && sw_cmd == TPC_CMD_TOGGLE)) begin
            ff_nxt = !ff_r;
        end

        // apb answer: one wait state, read data captured in the first access cycle
        pready_nxt  = rd_setup;
        prdata_nxt  = prdata_r;
        pslverr_nxt = 1'b0;
        if (rd_setup) begin
            prdata_nxt = 32'h0000_0000;
            case (paddr)
                TPC_ADDR_RUN:    prdata_nxt[7:0] = run_r;
                TPC_ADDR_MODE:   prdata_nxt[7:0] = mode_r;
                TPC_ADDR_CMP_LO: prdata_nxt[7:0] = cmp_lo_r;
                TPC_ADDR_CMP_HI: prdata_nxt[7:0] = cmp_hi_r;
                TPC_ADDR_TGL: begin
                    prdata_nxt[TPC_TGL_EN_BIT]  = tgl_en_r;
                    prdata_nxt[TPC_TGL_SEL_BIT] = tgl_sel_r;
                end
                TPC_ADDR_STAT: begin
                    prdata_nxt[15:0]            = {cnt_hi_r, cnt_lo_r};
                    prdata_nxt[TPC_STAT_FF_BIT] = ff_r;
                end
                default: pslverr_nxt = 1'b1;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            run_r     <= tpc_run_s'(TPC_RUN_RESET | {1'b0, TPC_RUN_ONES, 4'h0});
            mode_r    <= tpc_mode_s'(TPC_MODE_RESET);
            cmp_lo_r  <= 8'h00;
            buf_lo_r  <= 8'h00;
            cmp_hi_r  <= 8'h00;
            armed_r   <= 1'b0;
            tgl_en_r  <= 1'b0;
            tgl_sel_r <= 1'b0;
            presc_r   <= 9'h000;
            cnt_lo_r  <= 8'h00;
            cnt_hi_r  <= 8'h00;
            ff_r      <= 1'b0;
            irq_lo_r  <= 1'b0;
            irq_hi_r  <= 1'b0;
            prdata_r  <= 32'h0000_0000;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            ext_lvl_r <= 1'b0;
        end else begin
            run_r     <= run_nxt;
            mode_r    <= mode_nxt;
            cmp_lo_r  <= cmp_lo_nxt;
            buf_lo_r  <= buf_lo_nxt;
            cmp_hi_r  <= cmp_hi_nxt;
            armed_r   <= armed_nxt;
            tgl_en_r  <= tgl_en_nxt;
            tgl_sel_r <= tgl_sel_nxt;
            presc_r   <= presc_nxt;
            cnt_lo_r  <= cnt_lo_nxt;
            cnt_hi_r  <= cnt_hi_nxt;
            ff_r      <= ff_nxt;
            irq_lo_r  <= irq_lo_nxt;
            irq_hi_r  <= irq_hi_nxt;
            prdata_r  <= prdata_nxt;
            pready_r  <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            ext_lvl_r <= ext_lvl_nxt;
        end
    end

    assign prdata           = prdata_r;
    assign pready           = pready_r;
    assign pslverr          = pslverr_r;
    assign low_match_irq    = irq_lo_r;
    assign high_match_irq   = irq_hi_r;
    assign timer_output_pin = ff_r;

    ////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    low_match_clear_a: assert property (
        lo_match |=> (cnt_lo_r == 8'h00) && low_match_irq)
        else $error("low match did not clear counter and pulse irq");
    high_match_clear_a: assert property (
        hi_match |=> (cnt_hi_r == 8'h00) && high_match_irq)
        else $error("high match did not clear counter and pulse irq");
    toggle_invert_a: assert property (
        (hw_tgl && !sw_wr) |=> (ff_r != $past(ff_r)))
        else $error("enabled match did not invert output");
    late_compare_a: assert property (
        (mode == TPC_TIMER8) && lo_tick && (cmp_lo_r != 8'h00)
        && (cnt_lo_r >= cmp_lo_r) && (cnt_lo_r != 8'hff) && !wr_acc
        |=> !low_match_irq)
        else $error("match fired below current count");
    soft_clear_a: assert property (
        wr_acc && (paddr == TPC_ADDR_TGL) && (pwdata[1:0] == TPC_CMD_CLEAR)
        |=> !timer_output_pin)
        else $error("software clear did not win");
    soft_set_a: assert property (
        wr_acc && (paddr == TPC_ADDR_TGL) && (pwdata[1:0] == TPC_CMD_SET)
        |=> timer_output_pin)
        else $error("software set did not win");
    // a restart may tick in its first cycle, so only a held stop is checked
    stop_clear_a: assert property (
        !run_r.low_counter_run ##1 !run_r.low_counter_run
        |-> (cnt_lo_r == 8'h00) ##1 (cnt_lo_r == 8'h00))
        else $error("stopped low counter not held at zero");
    run_ones_a: assert property (
        rd_setup && !pwrite && (paddr == TPC_ADDR_RUN)
        |=> pready && (prdata[6:4] == 3'h7))
        else $error("run register bits 6:4 did not read as one");
    pwm_wrap_a: assert property (
        pwm_ovf && run_r.double_buffer_enable && !wr_acc
        |=> (cnt_lo_r == 8'h00) && (cmp_lo_r == $past(buf_lo_r)))
        else $error("pwm overflow did not wrap and load buffer");
    unarmed_16_a: assert property (
        (mode == TPC_TIMER16) && !armed_r |=> !high_match_irq)
        else $error("16-bit match while only low byte written");
    irq_pulse_a: assert property (
        low_match_irq |=> !low_match_irq)
        else $error("low irq longer than one cycle");
endmodule

// ---- tpc_pkg.sv ----
// package: register map, field layouts and modes of the timer pair
package tpc_pkg;
    localparam logic [11:0] TPC_ADDR_RUN    = 12'h100;
    localparam logic [11:0] TPC_ADDR_MODE   = 12'h104;
    localparam logic [11:0] TPC_ADDR_CMP_LO = 12'h108;
    localparam logic [11:0] TPC_ADDR_CMP_HI = 12'h10c;
    localparam logic [11:0] TPC_ADDR_TGL    = 12'h110;
    localparam logic [11:0] TPC_ADDR_STAT   = 12'h114;

    localparam logic [7:0]  TPC_RUN_RESET   = 8'h00;
    localparam logic [7:0]  TPC_MODE_RESET  = 8'h00;
    localparam logic [2:0]  TPC_RUN_ONES    = 3'h7;
    localparam int          TPC_STAT_FF_BIT = 16;
    localparam int          TPC_TGL_EN_BIT  = 2;
    localparam int          TPC_TGL_SEL_BIT = 3;

    localparam logic [3:0]  TPC_TAP_DIV2    = 4'h1;
    localparam logic [3:0]  TPC_TAP_DIV8    = 4'h3;
    localparam logic [3:0]  TPC_TAP_DIV32   = 4'h5;
    localparam logic [3:0]  TPC_TAP_DIV512  = 4'h9;

    localparam logic [7:0]  TPC_PWM_TOP_64  = 8'h3f;
    localparam logic [7:0]  TPC_PWM_TOP_128 = 8'h7f;
    localparam logic [7:0]  TPC_PWM_TOP_256 = 8'hff;

    localparam logic [1:0]  TPC_CMD_TOGGLE  = 2'h0;
    localparam logic [1:0]  TPC_CMD_CLEAR   = 2'h1;
    localparam logic [1:0]  TPC_CMD_SET     = 2'h2;

    typedef enum logic [1:0] {
        TPC_TIMER8  = 2'b00,
        TPC_TIMER16 = 2'b01,
        TPC_PPG     = 2'b10,
        TPC_PWM     = 2'b11
    } tpc_mode_e;

    typedef struct packed {
        logic       double_buffer_enable;
        logic [2:0] ones;
        logic       idle_keep_running;
        logic       prescaler_run;
        logic       high_counter_run;
        logic       low_counter_run;
    } tpc_run_s;

    typedef struct packed {
        tpc_mode_e  operating_mode_field;
        logic [1:0] pwm_cycle_field;
        logic [1:0] high_clock_select;
        logic [1:0] low_clock_select;
    } tpc_mode_s;
endpackage

// ---- tpc_timer_pair_test.sv ----
// testbench: register, period, toggle and idle behaviour of the timer pair
`timescale 1ns/100ps
module tpc_timer_pair_test;
    import tpc_pkg::*;
    logic        clk_sys            = 1'b0;
    logic        rstn               = 1'b0;
    logic        psel               = 1'b0;
    logic        penable            = 1'b0;
    logic        pwrite             = 1'b0;
    logic [11:0] paddr              = 12'h000;
    logic [31:0] pwdata             = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        external_count_pin = 1'b0;
    logic        idle_standby_state = 1'b0;
    logic        low_match_irq;
    logic        high_match_irq;
    logic        timer_output_pin;
    int          fails              = 0;
    int          compares           = 0;
    int          seed               = 32'h259a;
    logic        ff_m;
    logic [31:0] rd;
    logic        err;
    int          n;
    int          c;
    // period table: mode, low cmp, high cmp, run, high irq, toggles once, period
    logic [7:0]  t_mode[9] = '{8'h01, 8'h01, 8'h05, 8'h41, 8'hd1, 8'he1, 8'h02, 8'h03, 8'h81};
    logic [7:0]  t_lo[9]   = '{8'h02, 8'h00, 8'hff, 8'h02, 8'h0a, 8'h0a, 8'h03, 8'h02, 8'h03};
    logic [7:0]  t_hi[9]   = '{8'hff, 8'hff, 8'h02, 8'h01, 8'hff, 8'hff, 8'hff, 8'hff, 8'h05};
    logic [7:0]  t_run[9]  = '{8'h0d, 8'h0d, 8'h0e, 8'h0f, 8'h0d, 8'h0d, 8'h0d, 8'h0d, 8'h0d};
    logic        t_hirq[9] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
    logic        t_tgl[9]  = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
    int          t_exp[9]  = '{4, 512, 4, 516, 128, 256, 24, 64, 10};
    logic [1:0]  cmds[$]   = '{2'h1, 2'h2, 2'h0, 2'h0, 2'h3, 2'h1, 2'h0};

    tpc_timer_pair i_tpc_timer_pair (
        .clk_sys            (clk_sys),
        .rstn               (rstn),
        .psel               (psel),
        .penable            (penable),
        .pwrite             (pwrite),
        .paddr              (paddr),
        .pwdata             (pwdata),
        .prdata             (prdata),
        .pready             (pready),
        .pslverr            (pslverr),
        .external_count_pin (external_count_pin),
        .idle_standby_state (idle_standby_state),
        .low_match_irq      (low_match_irq),
        .high_match_irq     (high_match_irq),
        .timer_output_pin   (timer_output_pin)
    );

    always #2.5 clk_sys = ~clk_sys;

    // noise on the count pin; unused by every selected clock source here
    always @(posedge clk_sys) begin
        external_count_pin <= $random(seed);
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_sys);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        penable <= 1'b0;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) check("pready", 32'h0, 32'h1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask

    task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(what, rd, exp);
    endtask

    // counts edges until the chosen irq is sampled high
    task automatic wait_pulse(input logic hi, output int cnt);
        cnt = 0;
        do begin
            @(posedge clk_sys);
            cnt++;
        end while ((hi ? high_match_irq : low_match_irq) !== 1'b1 && cnt < 3000);
        if (cnt >= 3000) check("irq wait", 32'h0, 32'h1);
    endtask

    initial begin
        #200000;
        check("watchdog", 32'h0, 32'h1);
        report_and_stop();
    end

    initial begin
        logic p1;
        repeat (3) @(posedge clk_sys);
        rstn <= 1'b1;
        check("pin after reset", timer_output_pin, 1'b0);
        rd_chk("run reset", TPC_ADDR_RUN, 32'h70);
        rd_chk("mode reset", TPC_ADDR_MODE, 32'h0);
        wr(TPC_ADDR_RUN, 8'h08);
        rd_chk("run ones", TPC_ADDR_RUN, 32'h78);
        wr(TPC_ADDR_RUN, 8'h80);
        rd_chk("run bit7", TPC_ADDR_RUN, 32'hf0);
        wr(TPC_ADDR_RUN, 8'h00);
        c = $random(seed);
        wr(TPC_ADDR_MODE, c[7:0]);
        rd_chk("mode readback", TPC_ADDR_MODE, {24'h0, c[7:0]});
        apb(1'b0, 12'h118, 32'h0);
        check("unmapped err", err, 1'b1);
        check("unmapped data", rd, 32'h0);
        $display("test registers done");

        // toggle on selected low match, stopped while configuring
        wr(TPC_ADDR_TGL, 8'h07);
        c = 2 + ($unsigned($random(seed)) % 8);
        t_lo[0] = c[7:0];
        t_exp[0] = 2 * c;
        c = 2 + ($unsigned($random(seed)) % 8);
        t_hi[2] = c[7:0];
        t_exp[2] = 2 * c;
        for (int r = 0; r < 9; r++) begin
            wr(TPC_ADDR_RUN, 8'h00);
            wr(TPC_ADDR_MODE, t_mode[r]);
            wr(TPC_ADDR_CMP_LO, t_lo[r]);
            wr(TPC_ADDR_CMP_HI, t_hi[r]);
            wr(TPC_ADDR_RUN, t_run[r]);
            wait_pulse(t_hirq[r], n);
            @(posedge clk_sys);
            check("irq one cycle", t_hirq[r] ? high_match_irq : low_match_irq, 1'b0);
            p1 = timer_output_pin;
            wait_pulse(t_hirq[r], n);
            @(posedge clk_sys);
            check("irq period", n + 1, t_exp[r]);
            check("pin toggle", timer_output_pin, p1 ^ t_tgl[r]);
        end
        $display("test periods done");

        // compare lowered under the running count: no hit before the wrap
        wr(TPC_ADDR_RUN, 8'h00);
        wr(TPC_ADDR_MODE, 8'h01);
        wr(TPC_ADDR_CMP_LO, 8'h80);
        wr(TPC_ADDR_RUN, 8'h0d);
        repeat (40) @(posedge clk_sys);
        wr(TPC_ADDR_CMP_LO, 8'h02);
        wait_pulse(1'b0, n);
        check("late compare", n > 256, 1'b1);
        // pwm with double buffer: new compare only after the cycle overflow
        wr(TPC_ADDR_RUN, 8'h00);
        wr(TPC_ADDR_MODE, 8'hd1);
        wr(TPC_ADDR_CMP_LO, 8'h0a);
        wr(TPC_ADDR_RUN, 8'h8d);
        wr(TPC_ADDR_CMP_LO, 8'h20);
        rd_chk("buffer held", TPC_ADDR_CMP_LO, 32'h0a);
        wait_pulse(1'b0, n);
        rd_chk("buffer loaded", TPC_ADDR_CMP_LO, 32'h20);
        $display("test compare reload done");

        wr(TPC_ADDR_RUN, 8'h00);
        wr(TPC_ADDR_MODE, 8'h01);
        wr(TPC_ADDR_CMP_LO, 8'h80);
        idle_standby_state <= 1'b1;
        wr(TPC_ADDR_RUN, 8'h05);
        repeat (20) @(posedge clk_sys);
        apb(1'b0, TPC_ADDR_STAT, 32'h0);
        check("idle halt", rd[15:0], 16'h0);
        idle_standby_state <= 1'b0;
        repeat (20) @(posedge clk_sys);
        apb(1'b0, TPC_ADDR_STAT, 32'h0);
        check("counting", rd[7:0] != 8'h0, 1'b1);
        wr(TPC_ADDR_RUN, 8'h00);
        apb(1'b0, TPC_ADDR_STAT, 32'h0);
        check("stop clears", rd[15:0], 16'h0);
        $display("test run control done");

        // soft commands with match toggle disabled
        ff_m = timer_output_pin;
        foreach (cmds[i]) begin
            wr(TPC_ADDR_TGL, {6'h0, cmds[i]});
            case (cmds[i])
                2'h0: ff_m = ~ff_m;
                2'h1: ff_m = 1'b0;
                2'h2: ff_m = 1'b1;
                default: ff_m = ff_m;
            endcase
            @(posedge clk_sys);
            check("soft command", timer_output_pin, ff_m);
        end
        apb(1'b0, TPC_ADDR_STAT, 32'h0);
        check("stat ff", rd[TPC_STAT_FF_BIT], ff_m);
        $display("test soft commands done");
        report_and_stop();
    end
endmodule
